// ==== hdl/scp_pkg.sv ====
// constants, types and keyword tables for the program message parser
// Functional notes
// RQ1: parameter needs at least one preceding space
// RQ2: optional words accepted present or absent
// RQ3: 0/OFF disables, 1/ON enables
// RQ4: numbers: integer, decimal point or exponent
// RQ5: DEFault, MINimum, MAXimum replace a number
// RQ6: trailing question mark makes a query
// RQ7: query with DEF/MIN/MAX reports that value
// RQ8: keyword matching ignores letter case
// RQ9: only long or short spelling; else error
// RQ10: short form: three or four letters
// RQ11: query mark and suffix kept in short form
// RQ12: common command is asterisk plus three letters
// RQ13: path starts at root, colon descends
// RQ14: semicolons split commands, each processed
// RQ15: colon after semicolon returns to root
// RQ16: plain semicolon keeps level; misplaced word errors
// RQ17: message starts at root; optional root skipped
// RQ18: leading colon allowed, same result
// RQ19: path pointer never moves up
// RQ20: common command leaves path level alone
// RQ21: host ends message with LF or EOI
// RQ22: in order; error drops rest of message
package scp_pkg;
  localparam int MAXW = 11;
  localparam int NKW = 16;
  localparam int NPK = 5;
  localparam int BUF_DEPTH = 2;

  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_EXP = 8'h45;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5A;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // one keyword: name right-justified, first letter in the highest used byte
  typedef struct packed {
    logic [8*MAXW-1:0] name;
    logic [3:0] len;
    logic [4:0] parent;
    logic is_cmd;
    logic is_path;
    logic opt;
    logic sfx;
  } scp_kw_t;

  // header tree; entry 0 is the root
  localparam scp_kw_t KW_TAB [0:NKW] = '{
    '{88'h0, 4'h0, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{"STATUS", 4'h6, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0},
    '{"OPERATION", 4'h9, 5'h01, 1'b0, 1'b1, 1'b0, 1'b0},
    '{"PTRANSITION", 4'hB, 5'h02, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"NTRANSITION", 4'hB, 5'h02, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"ENABLE", 4'h6, 5'h02, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"PRESET", 4'h6, 5'h01, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"SYSTEM", 4'h6, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0},
    '{"PRESET", 4'h6, 5'h07, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"INITIATE", 4'h8, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0},
    '{"IMMEDIATE", 4'h9, 5'h09, 1'b1, 1'b0, 1'b1, 1'b0},
    '{"CONTINUOUS", 4'hA, 5'h09, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"SENSE", 4'h5, 5'h00, 1'b0, 1'b1, 1'b1, 1'b0},
    '{"CURRENT", 4'h7, 5'h0C, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"TRIGGER", 4'h7, 5'h00, 1'b0, 1'b1, 1'b0, 1'b0},
    '{"TIMER", 4'h5, 5'h0E, 1'b1, 1'b0, 1'b0, 1'b0},
    '{"LAYER", 4'h5, 5'h0E, 1'b1, 1'b0, 1'b0, 1'b1}
  };

  // parameter keywords, indices 1 and 3 to 5 match the kinds below; OFF at 2 is a bool too
  localparam scp_kw_t PK_TAB [1:NPK] = '{
    '{"ON", 4'h2, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{"OFF", 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{"DEFAULT", 4'h7, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{"MINIMUM", 4'h7, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{"MAXIMUM", 4'h7, 5'h00, 1'b0, 1'b0, 1'b0, 1'b0}
  };

  typedef enum logic [2:0] {PK_NONE, PK_BOOL, PK_NUM, PK_DEF, PK_MIN, PK_MAX} scp_pkind_t;
  typedef enum logic [1:0] {ER_NONE, ER_SYNTAX, ER_HEADER, ER_PARAM} scp_err_t;

  typedef struct packed {
    logic [7:0] data;
    logic eoi;
  } scp_rx_t;

  typedef struct packed {
    logic common;
    logic [4:0] node;
    logic [23:0] acro;
    logic query;
    logic [7:0] sfx;
    scp_pkind_t pkind;
    logic bval;
    logic neg;
    logic [31:0] mant;
    logic signed [7:0] exp10;
  } scp_cmd_t;
endpackage

// ==== hdl/scp_parser.sv ====
// program message parser: byte stream in, decoded commands out
`timescale 1ns/1ps
module scp_parser #(
  parameter int BUF_DEPTH = scp_pkg::BUF_DEPTH
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire scp_pkg::scp_rx_t RX_IN,
  input wire logic RX_VALID_IN,
  output logic RX_READY_OUT,
  output scp_pkg::scp_cmd_t CMD_OUT,
  output logic CMD_VALID_OUT,
  input wire logic CMD_READY_IN,
  output logic ERR_OUT,
  output scp_pkg::scp_err_t ERR_CODE_OUT,
  output logic MSG_DONE_OUT
);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam int MW = scp_pkg::MAXW;

  typedef enum logic [2:0] {ST_START, ST_HDR, ST_SP, ST_PKW, ST_PNUM, ST_PEND, ST_DROP} scp_st_t;

  // folds lower case onto upper case
  function automatic logic [7:0] fold(input logic [7:0] c);
    if (c >= scp_pkg::CH_LA && c <= scp_pkg::CH_LZ) return c & ~scp_pkg::CASE_BIT; // [RQ8]
    return c;
  endfunction

  // short spelling length of a keyword
  function automatic logic [3:0] short_len(input scp_pkg::scp_kw_t k);
    logic [7:0] c4;
    c4 = 8'h00;
    if (k.len <= 4'h4) return k.len; // [RQ10]
    c4 = k.name[8*(k.len-4) +: 8];
    if (c4 == "A" || c4 == "E" || c4 == "I" || c4 == "O" || c4 == "U" || c4 == "Y")
      return 4'h3; // [RQ10]
    return 4'h4; // [RQ10]
  endfunction

  // exact long or exact short spelling, suffix presence must agree
  function automatic logic kw_hit(input scp_pkg::scp_kw_t k, input logic [8*MW-1:0] w,
                                  input logic [3:0] wlen, input logic has_sfx);
    if (k.len == 4'h0 || k.sfx != has_sfx) return 1'b0; // [RQ11]
    if (wlen != k.len && wlen != short_len(k)) return 1'b0; // [RQ9]
    for (int i = 0; i < MW; i++) begin
      if (i < int'(wlen) && w[8*i +: 8] != k.name[8*(int'(k.len)-1-i) +: 8]) return 1'b0;
    end
    return 1'b1;
  endfunction

  // finds a header word below the current node
  function automatic logic [4:0] lookup(input logic [4:0] cur, input logic [8*MW-1:0] w,
                                        input logic [3:0] wlen, input logic has_sfx);
    logic [4:0] p;
    p = 5'h00;
    for (int e = 1; e <= scp_pkg::NKW; e++) begin
      p = scp_pkg::KW_TAB[e].parent;
      // at the root, children of an optional root stand in for it
      if ((p == cur || (cur == 5'h00 && p != 5'h00 && scp_pkg::KW_TAB[p].opt)) &&
          kw_hit(scp_pkg::KW_TAB[e], w, wlen, has_sfx)) // [RQ17]
        return 5'(e);
    end
    return 5'h00;
  endfunction

  // implied command word under a path node
  function automatic logic [4:0] opt_child(input logic [4:0] n);
    for (int e = 1; e <= scp_pkg::NKW; e++) begin
      if (scp_pkg::KW_TAB[e].parent == n && scp_pkg::KW_TAB[e].opt &&
          scp_pkg::KW_TAB[e].is_cmd) return 5'(e); // [RQ2]
    end
    return 5'h00;
  endfunction

  // input buffer
  scp_pkg::scp_rx_t mem [BUF_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] cnt;
  // parser state
  scp_st_t st;
  logic inj;
  logic colon_seen;
  logic [4:0] cur;
  logic [4:0] path;
  logic [4:0] pend_lvl;
  logic [8*MW-1:0] word;
  logic [3:0] wlen;
  logic has_sfx;
  logic [7:0] sfx;
  logic query;
  logic common;
  scp_pkg::scp_cmd_t pend;
  logic [31:0] mant;
  logic signed [7:0] exp_adj;
  logic [7:0] e_val;
  logic neg;
  logic n_dig;
  logic n_frac;
  logic n_exp;
  logic n_edig;
  logic n_esgn;
  logic e_neg;
  // decode
  logic stall;
  logic go;
  logic pop;
  logic [7:0] c;
  logic [7:0] u;
  logic [3:0] dig;
  logic is_alpha;
  logic is_dig;
  logic c_end;
  logic c_stop;
  logic [4:0] hdr_id;
  logic [4:0] fin_leaf;
  logic hdr_ok;
  logic [2:0] pm;
  logic num_ok;
  logic signed [7:0] exp_fin;
  logic fault;
  logic emit;
  scp_pkg::scp_cmd_t done_cmd;

  assign stall = CMD_VALID_OUT && !CMD_READY_IN;
  assign go = (cnt != '0 || inj) && !stall;
  assign pop = cnt != '0 && !inj && !stall;
  // an end-or-identify on a data byte is followed by a synthetic line feed
  assign c = inj ? scp_pkg::CH_LF : mem[rd_ptr].data;
  assign u = fold(c);
  assign dig = 4'(c - scp_pkg::CH_ZERO);
  assign is_alpha = u >= scp_pkg::CH_UA && u <= scp_pkg::CH_UZ;
  assign is_dig = c >= scp_pkg::CH_ZERO && c <= scp_pkg::CH_NINE;
  assign c_end = c == scp_pkg::CH_LF; // [RQ21]
  assign c_stop = c_end || c == scp_pkg::CH_SEMI; // [RQ14]
  assign RX_READY_OUT = cnt != CW'(BUF_DEPTH);

  // two-entry skid buffer ahead of the parser
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else begin
      if (RX_VALID_IN && RX_READY_OUT) begin
        mem[wr_ptr] <= RX_IN;
        wr_ptr <= (wr_ptr == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) rd_ptr <= (rd_ptr == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      cnt <= cnt + CW'(RX_VALID_IN && RX_READY_OUT) - CW'(pop);
    end
  end

  // word resolution on the current word registers
  always_comb begin
    hdr_id = lookup(cur, word, wlen, has_sfx); // [RQ13]
    if (scp_pkg::KW_TAB[hdr_id].is_cmd) fin_leaf = hdr_id;
    else if (scp_pkg::KW_TAB[hdr_id].is_path) fin_leaf = opt_child(hdr_id); // [RQ2]
    else fin_leaf = 5'h00;
    // common commands: asterisk and exactly three letters
    hdr_ok = common ? (wlen == 4'h3 && !has_sfx) : fin_leaf != 5'h00; // [RQ12]
    pm = 3'h0;
    for (int i = 1; i <= scp_pkg::NPK; i++) begin
      if (pm == 3'h0 && kw_hit(scp_pkg::PK_TAB[i], word, wlen, 1'b0)) pm = 3'(i);
    end
    num_ok = n_dig && (!n_exp || n_edig); // [RQ4]
    exp_fin = exp_adj + (e_neg ? -$signed(e_val) : $signed(e_val));
  end

  // per-character legality and command completion
  always_comb begin
    fault = 1'b0;
    emit = 1'b0;
    case (st)
      ST_START: begin
        if (c == scp_pkg::CH_COLON || c == scp_pkg::CH_STAR) fault = colon_seen;
        else if (c_end) fault = colon_seen;
        else if (!(c == scp_pkg::CH_SP || is_alpha)) fault = 1'b1;
      end
      ST_HDR: begin
        if (is_alpha) fault = has_sfx || query || wlen == 4'(MW);
        else if (is_dig) fault = common || wlen == 4'h0 || query;
        else if (c == scp_pkg::CH_QUERY) fault = query; // [RQ6]
        else if (c == scp_pkg::CH_COLON)
          fault = common || query || !scp_pkg::KW_TAB[hdr_id].is_path; // [RQ13]
        else if (c == scp_pkg::CH_SP || c_stop) begin
          fault = !hdr_ok; // [RQ9]
          emit = c_stop;
        end else fault = 1'b1; // [RQ1]
      end
      ST_SP: begin
        if (c_stop) emit = 1'b1;
        else if (!(c == scp_pkg::CH_SP || is_alpha || is_dig || c == scp_pkg::CH_DOT ||
                   c == scp_pkg::CH_PLUS || c == scp_pkg::CH_MINUS)) fault = 1'b1;
      end
      ST_PKW: begin
        if (is_alpha) fault = wlen == 4'(MW);
        else if (c == scp_pkg::CH_SP || c_stop) begin
          fault = pm == 3'h0; // [RQ5]
          emit = c_stop;
        end else fault = 1'b1;
      end
      ST_PNUM: begin
        if (is_dig) fault = 1'b0;
        else if (c == scp_pkg::CH_DOT) fault = n_frac || n_exp;
        else if (u == scp_pkg::CH_EXP) fault = n_exp || !n_dig;
        else if (c == scp_pkg::CH_PLUS || c == scp_pkg::CH_MINUS)
          fault = !n_exp || n_edig || n_esgn;
        else if (c == scp_pkg::CH_SP || c_stop) begin
          fault = !num_ok; // [RQ4]
          emit = c_stop;
        end else fault = 1'b1;
      end
      ST_PEND: begin
        if (c_stop) emit = 1'b1;
        else if (c != scp_pkg::CH_SP) fault = 1'b1;
      end
      default: begin
        fault = 1'b0;
      end
    endcase
    if (!go || fault) emit = 1'b0; // [RQ22]
    if (!go) fault = 1'b0;
  end

  // the command as it leaves, header fields or pending plus parameter
  always_comb begin
    done_cmd = pend;
    if (st == ST_HDR) begin
      done_cmd = '0;
      done_cmd.common = common;
      done_cmd.node = common ? 5'h00 : fin_leaf;
      done_cmd.acro = word[23:0];
      done_cmd.query = query; // [RQ6]
      done_cmd.sfx = sfx;
      done_cmd.pkind = scp_pkg::PK_NONE;
    end else if (st == ST_PKW) begin
      // a query carrying DEF/MIN/MAX asks for that limit
      case (pm)
        3'h1: done_cmd.pkind = scp_pkg::PK_BOOL; // [RQ3]
        3'h2: done_cmd.pkind = scp_pkg::PK_BOOL; // [RQ3]
        3'h3: done_cmd.pkind = scp_pkg::PK_DEF; // [RQ5] [RQ7]
        3'h4: done_cmd.pkind = scp_pkg::PK_MIN; // [RQ5] [RQ7]
        default: done_cmd.pkind = scp_pkg::PK_MAX; // [RQ5] [RQ7]
      endcase
      done_cmd.bval = pm == 3'h1; // [RQ3]
    end else if (st == ST_PNUM) begin
      done_cmd.pkind = scp_pkg::PK_NUM;
      done_cmd.mant = mant;
      done_cmd.neg = neg;
      done_cmd.exp10 = exp_fin;
      done_cmd.bval = mant != 32'h0; // [RQ3]
    end
  end

  // parser walk through the message
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      st <= ST_START;
      inj <= 1'b0;
      colon_seen <= 1'b0;
      cur <= 5'h00;
      path <= 5'h00;
      pend_lvl <= 5'h00;
      word <= '0;
      wlen <= 4'h0;
      has_sfx <= 1'b0;
      sfx <= 8'h00;
      query <= 1'b0;
      common <= 1'b0;
      pend <= '0;
      mant <= 32'h0;
      exp_adj <= 8'sh00;
      e_val <= 8'h00;
      neg <= 1'b0;
      {n_dig, n_frac, n_exp, n_edig, n_esgn, e_neg} <= 6'h00;
    end else if (go) begin
      inj <= pop && mem[rd_ptr].eoi && mem[rd_ptr].data != scp_pkg::CH_LF; // [RQ21]
      if (fault && !c_end) st <= ST_DROP; // [RQ22]
      else if (c_end) begin
        // every new message starts again at the root
        st <= ST_START;
        cur <= 5'h00; // [RQ17]
        path <= 5'h00;
        colon_seen <= 1'b0;
        wlen <= 4'h0;
      end else if (emit) begin
        // sibling commands continue at the level just used
        st <= ST_START;
        path <= (st == ST_HDR) ? (common ? path : scp_pkg::KW_TAB[fin_leaf].parent) : pend_lvl;
        cur <= (st == ST_HDR) ? (common ? path : scp_pkg::KW_TAB[fin_leaf].parent) : pend_lvl; // [RQ16] [RQ20]
        colon_seen <= 1'b0;
        wlen <= 4'h0;
      end else begin
        case (st)
          ST_START: begin
            if (c == scp_pkg::CH_COLON) begin
              colon_seen <= 1'b1;
              cur <= 5'h00; // [RQ15] [RQ18]
            end else if (c == scp_pkg::CH_STAR || is_alpha) begin
              st <= ST_HDR;
              common <= c == scp_pkg::CH_STAR; // [RQ12]
              word <= '0;
              word[7:0] <= u;
              wlen <= (c == scp_pkg::CH_STAR) ? 4'h0 : 4'h1;
              {has_sfx, query} <= 2'b00;
              sfx <= 8'h00;
            end
          end
          ST_HDR: begin
            if (is_alpha) begin
              word[8*wlen +: 8] <= u;
              wlen <= wlen + 4'h1;
            end else if (is_dig) begin
              has_sfx <= 1'b1; // [RQ11]
              sfx <= 8'(sfx * 8'h0A) + {4'h0, dig};
            end else if (c == scp_pkg::CH_QUERY) query <= 1'b1;
            else if (c == scp_pkg::CH_COLON) begin
              cur <= hdr_id; // [RQ13] [RQ19]
              word <= '0;
              wlen <= 4'h0;
              has_sfx <= 1'b0;
              sfx <= 8'h00;
            end else begin
              // header done by a space: hold it while the parameter arrives
              st <= ST_SP; // [RQ1]
              pend <= done_cmd;
              pend_lvl <= common ? path : scp_pkg::KW_TAB[fin_leaf].parent; // [RQ20]
            end
          end
          ST_SP: begin
            if (is_alpha) begin
              st <= ST_PKW;
              word <= '0;
              word[7:0] <= u;
              wlen <= 4'h1;
            end else if (c != scp_pkg::CH_SP) begin
              st <= ST_PNUM;
              mant <= is_dig ? {28'h0, dig} : 32'h0;
              n_dig <= is_dig;
              n_frac <= c == scp_pkg::CH_DOT;
              neg <= c == scp_pkg::CH_MINUS;
              exp_adj <= 8'sh00;
              e_val <= 8'h00;
              {n_exp, n_edig, n_esgn, e_neg} <= 4'h0;
            end
          end
          ST_PKW: begin
            if (is_alpha) begin
              word[8*wlen +: 8] <= u;
              wlen <= wlen + 4'h1;
            end else begin
              st <= ST_PEND;
              pend <= done_cmd;
            end
          end
          ST_PNUM: begin
            if (is_dig && n_exp) begin
              e_val <= 8'(e_val * 8'h0A) + {4'h0, dig};
              n_edig <= 1'b1;
            end else if (is_dig) begin
              // mantissa wraps past 32 bits; long digit strings are a limitation
              mant <= (mant * 32'h0000000A) + {28'h0, dig};
              n_dig <= 1'b1;
              if (n_frac) exp_adj <= exp_adj - 8'sh01; // [RQ4]
            end else if (c == scp_pkg::CH_DOT) n_frac <= 1'b1;
            else if (u == scp_pkg::CH_EXP) n_exp <= 1'b1; // [RQ4]
            else if (c == scp_pkg::CH_PLUS || c == scp_pkg::CH_MINUS) begin
              n_esgn <= 1'b1;
              e_neg <= c == scp_pkg::CH_MINUS;
            end else begin
              st <= ST_PEND;
              pend <= done_cmd;
            end
          end
          default: begin
            st <= st;
          end
        endcase
      end
    end
  end

  // command output register, held until taken
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      CMD_OUT <= '0;
      CMD_VALID_OUT <= 1'b0;
    end else if (emit) begin
      CMD_OUT <= done_cmd; // [RQ22]
      CMD_VALID_OUT <= 1'b1;
    end else if (CMD_READY_IN) begin
      CMD_VALID_OUT <= 1'b0;
    end
  end

  // error and message end pulses
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN) begin
      ERR_OUT <= 1'b0;
      ERR_CODE_OUT <= scp_pkg::ER_NONE;
      MSG_DONE_OUT <= 1'b0;
    end else begin
      ERR_OUT <= fault; // [RQ9] [RQ22]
      if (fault) begin
        case (st)
          ST_START: ERR_CODE_OUT <= scp_pkg::ER_SYNTAX;
          ST_HDR: ERR_CODE_OUT <= scp_pkg::ER_HEADER;
          default: ERR_CODE_OUT <= scp_pkg::ER_PARAM;
        endcase
      end
      MSG_DONE_OUT <= go && c_end;
    end
  end
endmodule // scp_parser

// ==== test/scp_parser_monitor.sv ====
// concurrent checks on the program message parser ports
`timescale 1ns/1ps
module scp_parser_monitor #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire scp_pkg::scp_rx_t RX_IN,
  input wire logic RX_VALID_IN,
  input wire logic RX_READY_OUT,
  input wire scp_pkg::scp_cmd_t CMD_OUT,
  input wire logic CMD_VALID_OUT,
  input wire logic CMD_READY_IN,
  input wire logic ERR_OUT,
  input wire scp_pkg::scp_err_t ERR_CODE_OUT,
  input wire logic MSG_DONE_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  logic drop;

  // rest of a failed message is dropped; cleared when its terminator is processed
  always_ff @(posedge CLK_IN) begin
    if (!RST_B_IN || MSG_DONE_OUT) begin
      drop <= 1'b0;
    end else if (ERR_OUT) begin
      drop <= 1'b1;
    end
  end

  property p_hold;
    CMD_VALID_OUT && !CMD_READY_IN |=> CMD_VALID_OUT && $stable(CMD_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("command changed before taken");

  // a still-pending command may stay, but nothing new after an error
  property p_drop;
    drop && CMD_VALID_OUT |-> $past(CMD_VALID_OUT) && !$past(CMD_READY_IN);
  endproperty
  a_drop: assert property (p_drop) else $error("command after error");

  property p_rst;
    @(posedge CLK_IN) disable iff (1'b0)
    !RST_B_IN |=> !CMD_VALID_OUT && !ERR_OUT && !MSG_DONE_OUT && RX_READY_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");

  property p_common;
    CMD_VALID_OUT && CMD_OUT.common |-> CMD_OUT.node == 5'h00;
  endproperty
  a_common: assert property (p_common) else $error("common command has node");

  property p_node;
    CMD_VALID_OUT && !CMD_OUT.common |-> scp_pkg::KW_TAB[CMD_OUT.node].is_cmd;
  endproperty
  a_node: assert property (p_node) else $error("path word executed");

  property p_upper;
    CMD_VALID_OUT && CMD_OUT.common |-> (CMD_OUT.acro[7:0] inside {[8'h41:8'h5A]})
      && (CMD_OUT.acro[15:8] inside {[8'h41:8'h5A]})
      && (CMD_OUT.acro[23:16] inside {[8'h41:8'h5A]});
  endproperty
  a_upper: assert property (p_upper) else $error("acronym not folded");

  property p_code;
    ERR_OUT |-> ERR_CODE_OUT != scp_pkg::ER_NONE;
  endproperty
  a_code: assert property (p_code) else $error("error without code");

  // guarded by the previous reset level so a clearing reset does not trip it
  property p_chold;
    !ERR_OUT && $past(RST_B_IN) |-> $stable(ERR_CODE_OUT);
  endproperty
  a_chold: assert property (p_chold) else $error("error code moved");
endmodule // scp_parser_monitor

bind scp_parser scp_parser_monitor #(.BUF_DEPTH(BUF_DEPTH)) mon_u (
  .CLK_IN(CLK_IN),
  .RST_B_IN(RST_B_IN),
  .RX_IN(RX_IN),
  .RX_VALID_IN(RX_VALID_IN),
  .RX_READY_OUT(RX_READY_OUT),
  .CMD_OUT(CMD_OUT),
  .CMD_VALID_OUT(CMD_VALID_OUT),
  .CMD_READY_IN(CMD_READY_IN),
  .ERR_OUT(ERR_OUT),
  .ERR_CODE_OUT(ERR_CODE_OUT),
  .MSG_DONE_OUT(MSG_DONE_OUT)
);

// ==== test/scp_host.sv ====
// host model: offers program messages byte by byte
`timescale 1ns/1ps
module scp_host (
  input wire logic clk_in,
  input wire logic ready_in,
  output scp_pkg::scp_rx_t rx_out,
  output logic valid_out
);
  initial begin
    rx_out = '0;
    valid_out = 1'b0;
  end

  // each byte held until taken; gap makes the host slow between bytes
  task automatic send(input string s, input bit eoi, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      rx_out <= '{data: s[i], eoi: eoi && (i == s.len() - 1)};
      valid_out <= 1'b1;
      @(posedge clk_in);
      while (!ready_in) @(posedge clk_in);
      if (gap > 0) begin
        valid_out <= 1'b0;
        rx_out <= ~rx_out; // released lines must not look like the last byte
        repeat (gap) @(posedge clk_in);
      end
    end
    valid_out <= 1'b0;
    rx_out <= ~rx_out;
  endtask
endmodule // scp_host

// ==== test/tb_scp_parser.sv ====
// self-checking bench for the program message parser
`timescale 1ns/1ps
module tb_scp_parser;
  typedef struct {
    string msg;
    bit eoi;
    int n;
    bit err;
    logic [4:0] node;
    logic [2:0] pk;
    logic q;
    logic b;
    logic [31:0] mant;
    logic signed [7:0] e;
  } scp_row_t;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  scp_pkg::scp_rx_t rx;
  logic rx_valid;
  logic rx_ready;
  scp_pkg::scp_cmd_t cmd;
  scp_pkg::scp_cmd_t last;
  logic cmd_valid;
  logic cmd_ready = 1'b0;
  logic err;
  scp_pkg::scp_err_t err_code;
  logic done;
  logic stall = 1'b0;
  logic [1:0] cyc = 2'h0;
  int ncmd = 0;
  int nerr = 0;
  int ndone = 0;
  int mismatches = 0;
  int checks_done = 0;

  // kinds: 0 none, 1 bool, 2 num, 3 def, 4 min, 5 max
  scp_row_t rows [0:25] = '{
    '{"stat:oper:enab 5;ptr 1E1\n", 0, 2, 0, 5'h03, 3'h2, 0, 0, 32'h1, 8'h01},
    '{"sTaT:pReS\n", 0, 1, 0, 5'h06, 3'h0, 0, 0, 32'h0, 8'h00},
    '{":stat:pres\n", 0, 1, 0, 5'h06, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"init\n", 0, 1, 0, 5'h0A, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"INIT:IMM\n", 0, 1, 0, 5'h0A, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"curr 2.5\n", 0, 1, 0, 5'h0D, 3'h2, 0, 0, 32'h19, 8'hFF},
    '{"sens:curr 8\n", 0, 1, 0, 5'h0D, 3'h2, 0, 0, 32'h8, 8'h00},
    '{"trig:tim 2.3E6\n", 0, 1, 0, 5'h0F, 3'h2, 0, 0, 32'h17, 8'h05},
    '{"trig:tim? max\n", 0, 1, 0, 5'h0F, 3'h5, 1, 0, 32'h0, 8'h00},
    '{"trigger:timer def\n", 0, 1, 0, 5'h0F, 3'h3, 0, 0, 32'h0, 8'h00},
    '{"trig:tim min\n", 0, 1, 0, 5'h0F, 3'h4, 0, 0, 32'h0, 8'h00},
    '{"init:cont on\n", 0, 1, 0, 5'h0B, 3'h1, 0, 1, 32'h0, 8'h00},
    '{"init:cont OFF\n", 0, 1, 0, 5'h0B, 3'h1, 0, 0, 32'h0, 8'h00},
    '{"init:cont 1\n", 0, 1, 0, 5'h0B, 3'h2, 0, 1, 32'h1, 8'h00},
    '{"init:cont 0\n", 0, 1, 0, 5'h0B, 3'h2, 0, 0, 32'h0, 8'h00},
    '{"trig:lay2?\n", 0, 1, 0, 5'h10, 3'h0, 1, 0, 32'h0, 8'h00},
    '{"trig:lay?\n", 0, 0, 1, 5'h00, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"syste:pres\n", 0, 0, 1, 5'h00, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"stat:oper:ptr1\n", 0, 0, 1, 5'h00, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"*rst\n", 0, 1, 0, 5'h00, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"stat:oper:enab 5;*ese 3;ntr 2\n", 0, 3, 0, 5'h04, 3'h2, 0, 0, 32'h2, 8'h00},
    '{"stat:oper:enab 1;:ptr 2\n", 0, 1, 1, 5'h05, 3'h2, 0, 0, 32'h1, 8'h00},
    '{"stat:pres;:syst:pres\n", 0, 2, 0, 5'h08, 3'h0, 0, 0, 32'h0, 8'h00},
    '{"stat:oper:enab 1;pres\n", 0, 1, 1, 5'h05, 3'h2, 0, 0, 32'h1, 8'h00},
    '{"init:cont on", 1, 1, 0, 5'h0B, 3'h1, 0, 1, 32'h0, 8'h00},
    '{"stat:oper:enab 4;ptr 2;;ntr 3\n", 0, 2, 1, 5'h03, 3'h2, 0, 0, 32'h2, 8'h00}
  };

  scp_parser dut_u (
    .CLK_IN(clk),
    .RST_B_IN(rst_b),
    .RX_IN(rx),
    .RX_VALID_IN(rx_valid),
    .RX_READY_OUT(rx_ready),
    .CMD_OUT(cmd),
    .CMD_VALID_OUT(cmd_valid),
    .CMD_READY_IN(cmd_ready),
    .ERR_OUT(err),
    .ERR_CODE_OUT(err_code),
    .MSG_DONE_OUT(done)
  );

  scp_host host_u (
    .clk_in(clk),
    .ready_in(rx_ready),
    .rx_out(rx),
    .valid_out(rx_valid)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // consumer stalls one cycle in four, or fully while stall is set
  always @(posedge clk) begin
    cyc <= cyc + 2'h1;
    cmd_ready <= !stall && (cyc != 2'h3);
    if (cmd_valid && cmd_ready) begin
      ncmd++;
      last = cmd;
    end
    if (err) nerr++;
    if (done) ndone++;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waits for the terminator and for the last command to be taken
  task automatic wait_done();
    int k;
    k = 0;
    while ((ndone == 0 || cmd_valid) && k < 400) begin
      @(posedge clk);
      #1;
      k++;
    end
    cmp(k < 400, 1'b1);
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    scp_row_t r;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      ncmd = 0;
      nerr = 0;
      ndone = 0;
      host_u.send(r.msg, r.eoi, i % 3);
      wait_done();
      cmp(ncmd, r.n);
      cmp(nerr != 0, r.err);
      cmp(ndone, 1);
      if (r.n > 0) begin
        cmp(last.node, r.node);
        cmp(last.query, r.q);
        cmp(last.pkind, r.pk);
        if (r.pk == 3'h1) cmp(last.bval, r.b);
        // a numeric 1 or 0 arrives as a number; nonzero means enable
        if (r.pk == 3'h2) cmp(last.bval, r.mant != 32'h0);
        if (r.pk == 3'h2) cmp(last.mant, r.mant);
        if (r.pk == 3'h2) cmp(last.exp10, r.e);
      end
      $display("row %0d done", i);
    end
    // the empty command in the last row leaves a held syntax code
    cmp(err_code, scp_pkg::ER_SYNTAX);
    // consumer stalls until the two-entry buffer refuses, then drains
    ncmd = 0;
    ndone = 0;
    stall = 1'b1;
    fork
      host_u.send("stat:oper:enab 1;ptr 2;ntr 3\n", 1'b0, 0);
    join_none
    repeat (40) @(posedge clk);
    cmp(rx_ready, 1'b0);
    cmp(ncmd, 0);
    stall = 1'b0;
    wait_done();
    cmp(ncmd, 3);
    cmp(last.node, 5'h04);
    cmp(last.mant, 32'h3);
    cmp(rx_ready, 1'b1);
    $display("buffer test done");
    // reset in mid-message with a command pending
    stall = 1'b1;
    fork
      host_u.send("stat:oper:enab 1;ptr 2\n", 1'b0, 0);
    join_none
    repeat (30) @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    cmp(cmd_valid, 1'b0);
    cmp(rx_ready, 1'b1);
    @(posedge clk);
    rst_b <= 1'b1;
    stall = 1'b0;
    ndone = 0;
    wait_done();
    ncmd = 0;
    ndone = 0;
    host_u.send("*rst\n", 1'b0, 1);
    wait_done();
    cmp(ncmd, 1);
    cmp(last.common, 1'b1);
    cmp(last.acro, 24'h545352);
    $display("reset test done");
    // a name parameter outside the keyword list is refused as a parameter fault
    ndone = 0;
    host_u.send("init:cont xx\n", 1'b0, 0);
    wait_done();
    cmp(err_code, scp_pkg::ER_PARAM);
    $display("param test done");
    tally_and_finish();
  end
endmodule // tb_scp_parser
